// File: tws_map.svh
// constants for the two-wire slave mode and status block
// Summary of operation
// R01 - master sends high-speed code first after start
// R02 - device nacks code, switches filters high-speed
// R03 - master follows code with normal address
// R04 - high-speed persists over restarts until stop
// R05 - stop returns filters to fast mode
// R06 - line low 30ms in transaction resets interface
// R07 - timeout releases driven line, waits for start
// R08 - master keeps clock at least 1kHz
// R09 - shutdown bit: finish conversion, then shut down
// R10 - shutdown keeps serial interface running
// R11 - shutdown clear: convert continuously
// R12 - shorted sensor reports minus 64 code
// R13 - open fault sets result bit 0
// R14 - invalid supply skips conversion
// R15 - invalid supply sets result bit 1
// R16 - write pointer first; reads use last pointer
// R17 - stuck counter on system clock, cleared idle
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH
`define TWS_CLK_HZ 40000000
`define TWS_STUCK_MS 30
`define TWS_STUCK_CYC ((`TWS_CLK_HZ / 1000) * `TWS_STUCK_MS)
`define TWS_HS_CODE_TOP 5'h01
`define TWS_SD_BIT 6
`define TWS_OPEN_BIT 0
`define TWS_SUPPLY_BIT 1
`define TWS_SHORT_CODE 16'hC000
`define TWS_CONV_CYC 16'h0FFF
`endif

// File: tws_pkg.sv
// types for the two-wire slave mode and status block
package tws_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {
    TWS_IDLE = 2'b00,
    TWS_CONV = 2'b01,
    TWS_DOWN = 2'b10
  } tws_conv_t;
  // bus condition events seen on the system clock side
  typedef struct packed {
    logic start;
    logic stop;
  } tws_cond_t;
  // analog comparator inputs
  typedef struct packed {
    logic open_fault;
    logic short_fault;
    logic supply_ok;
  } tws_sense_t;
endpackage

// File: tws_mode_status.sv
// two-wire slave speed mode, timeout and conversion status logic
`timescale 1ns/1ps
`include "tws_map.svh"
module tws_mode_status (
  // system clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // bus pins, scl also clocks the link domain
  input wire logic scl_in,
  input wire logic sda_in,
  // slave core request to pull sda low
  input wire logic core_sda_low_in,
  // byte from the slave core, with pulse at ack slot (link domain)
  input wire logic [7:0] link_byte_in,
  input wire logic link_byte_first_in,
  input wire logic link_byte_done_in,
  // configuration byte, only bit 6 is used
  input wire logic [7:0] config1_in,
  // comparators and converter result
  input wire tws_pkg::tws_sense_t sense_in,
  input wire logic [15:0] adc_result_in,
  // bus outputs
  output logic sda_out,
  output logic sda_oe_out,
  output logic hs_mode_out,
  output logic hs_nack_out,
  output logic iface_reset_out,
  // conversion status
  output logic conv_busy_out,
  output logic shutdown_out,
  output logic analog_en_out,
  output logic [15:0] temp_result_out,
  output logic result_valid_out
);
  import tws_pkg::*;

  // two-flop synchronisers for pins
  logic scl_m, scl_s, sda_m, sda_s;
  // delayed copies for edge detection
  logic scl_d, sda_d;
  // start and stop strobes
  tws_cond_t cond;
  // transaction open between start and stop
  logic in_txn;
  // high-speed filter select
  logic hs_mode;
  // cycles with a line held low
  logic [23:0] stuck_cnt;
  // off the bus after a timeout
  logic locked_out;
  // link-domain code detect toggle and its crossing
  logic hs_tog_l;
  logic hs_tog_m, hs_tog_s, hs_tog_d;
  // pointer slot open after a write address (link domain)
  logic ptr_slot_l;
  // last written pointer byte (link domain)
  logic [7:0] ptr_l;
  // conversion sequencer state and cycle count
  tws_conv_t conv_state;
  logic [15:0] conv_cnt;
  // last cycle of a conversion
  logic conv_end;
  // open comparator tripped during this conversion
  logic open_seen;

  // pin synchronisers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // start and stop conditions while scl is high
  always_comb begin
    cond.start = scl_s && scl_d && sda_d && !sda_s;
    cond.stop = scl_s && scl_d && !sda_d && sda_s;
  end

  // high-speed code detect on scl: first byte after start is 0000_1xxx
  always_ff @(posedge scl_in) begin
    if (srst_in) begin
      hs_tog_l <= 1'b0;
    end else if (link_byte_done_in && link_byte_first_in &&
                 link_byte_in[7:3] == `TWS_HS_CODE_TOP) begin
      hs_tog_l <= ~hs_tog_l; // see R02
    end
  end

  // pointer capture: the byte after a write address selects a register
  // a new start brings a fresh first byte, which reopens the slot only for a write address
  always_ff @(posedge scl_in) begin
    if (srst_in) begin
      ptr_slot_l <= 1'b0;
      ptr_l <= 8'h00;
    end else if (link_byte_done_in && link_byte_first_in) begin
      // direction bit low and not the speed code: pointer follows
      ptr_slot_l <= !link_byte_in[0] &&
                    link_byte_in[7:3] != `TWS_HS_CODE_TOP; // see R16
    end else if (link_byte_done_in && ptr_slot_l) begin
      // later reads use this pointer until the next write
      ptr_l <= link_byte_in; // see R16
      ptr_slot_l <= 1'b0;
    end
  end

  // toggle crossing into system clock
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_tog_m <= 1'b0;
      hs_tog_s <= 1'b0;
      hs_tog_d <= 1'b0;
    end else begin
      hs_tog_m <= hs_tog_l;
      hs_tog_s <= hs_tog_m;
      hs_tog_d <= hs_tog_s;
    end
  end

  // transaction open between start and stop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      in_txn <= 1'b0;
    end else if (cond.start) begin
      in_txn <= 1'b1;
    end else if (cond.stop || iface_reset_out) begin
      in_txn <= 1'b0; // see R06
    end
  end

  // speed mode: set on code, kept over restarts, cleared on stop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      hs_mode <= 1'b0;
    end else if (cond.stop || iface_reset_out) begin
      hs_mode <= 1'b0; // see R04 see R05
    end else if (hs_tog_s != hs_tog_d) begin
      hs_mode <= 1'b1; // see R02
    end
  end
  assign hs_mode_out = hs_mode;

  // code byte left unacknowledged: core drive masked while flagged
  assign hs_nack_out = link_byte_first_in &&
                       link_byte_in[7:3] == `TWS_HS_CODE_TOP; // see R02

  // bus stuck counter, cleared while both lines high
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      stuck_cnt <= 24'h000000;
    end else if ((scl_s && sda_s) || !in_txn) begin
      stuck_cnt <= 24'h000000; // see R17
    end else if (stuck_cnt != 24'(`TWS_STUCK_CYC)) begin
      stuck_cnt <= stuck_cnt + 24'h000001;
    end
  end
  assign iface_reset_out = stuck_cnt == 24'(`TWS_STUCK_CYC); // see R06

  // after timeout stay off the bus until a new start
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      locked_out <= 1'b0;
    end else if (cond.start) begin
      locked_out <= 1'b0; // see R07
    end else if (iface_reset_out) begin
      locked_out <= 1'b1; // see R07
    end
  end

  // open-drain drive of sda
  always_comb begin
    sda_out = 1'b0;
    sda_oe_out = core_sda_low_in && !locked_out && !hs_nack_out; // see R07
  end

  // conversion sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      conv_state <= TWS_IDLE;
      conv_cnt <= 16'h0000;
    end else begin
      case (conv_state)
        TWS_IDLE: begin
          conv_cnt <= 16'h0000;
          if (config1_in[`TWS_SD_BIT]) begin
            conv_state <= TWS_DOWN; // see R09
          end else if (sense_in.supply_ok) begin
            conv_state <= TWS_CONV; // see R11 see R14
          end
        end
        TWS_CONV: begin
          if (conv_cnt == `TWS_CONV_CYC) begin
            conv_state <= TWS_IDLE; // finish before shutdown, see R09
          end else begin
            conv_cnt <= conv_cnt + 16'h0001;
          end
        end
        TWS_DOWN: begin
          if (!config1_in[`TWS_SD_BIT]) begin
            conv_state <= TWS_IDLE; // see R11
          end
        end
        default: begin
          conv_state <= TWS_IDLE;
        end
      endcase
    end
  end
  assign conv_busy_out = conv_state == TWS_CONV;
  assign shutdown_out = conv_state == TWS_DOWN;
  // serial logic is never gated by shutdown
  assign analog_en_out = conv_state != TWS_DOWN; // see R10
  // last count of a running conversion, where the result is taken
  assign conv_end = conv_state == TWS_CONV && conv_cnt == `TWS_CONV_CYC;

  // open comparator watched throughout the conversion
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      open_seen <= 1'b0;
    end else if (conv_state == TWS_IDLE) begin
      open_seen <= 1'b0;
    end else if (conv_state == TWS_CONV && sense_in.open_fault) begin
      open_seen <= 1'b1; // see R13
    end
  end

  // result register with fault flags
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      temp_result_out <= 16'h0000;
      result_valid_out <= 1'b0;
    end else if (conv_end) begin
      temp_result_out <= sense_in.short_fault ? `TWS_SHORT_CODE
                         : adc_result_in; // see R12
      temp_result_out[`TWS_OPEN_BIT] <= open_seen || sense_in.open_fault;
      temp_result_out[`TWS_SUPPLY_BIT] <= !sense_in.supply_ok; // see R15
      result_valid_out <= 1'b1;
    end else if (conv_state == TWS_IDLE && !sense_in.supply_ok &&
                 !config1_in[`TWS_SD_BIT]) begin
      temp_result_out[`TWS_SUPPLY_BIT] <= 1'b1; // see R14 see R15
      result_valid_out <= 1'b1;
    end
  end

  // checks on mode, timeout and conversion status
  // speed mode drops one cycle after stop
  a_stop_ends_hs: assert property (@(posedge clk_in) disable iff (srst_in)
    cond.stop |=> !hs_mode) // see R05
    else $error("hs mode survived stop");

  // speed mode kept over restarts until stop or timeout
  a_hs_holds: assert property (@(posedge clk_in) disable iff (srst_in)
    hs_mode && !cond.stop && !iface_reset_out |=> hs_mode) // see R04
    else $error("hs mode dropped without stop");

  // start opens the transaction window
  a_start_opens: assert property (@(posedge clk_in) disable iff (srst_in)
    cond.start |=> in_txn) // see R06
    else $error("transaction not opened by start");

  // timeout closes the transaction and locks the slave out
  a_timeout_fires: assert property (@(posedge clk_in) disable iff (srst_in)
    iface_reset_out |=> !in_txn && locked_out) // see R06
    else $error("timeout did not reset interface");

  // no sda drive while locked out
  a_locked_release: assert property (@(posedge clk_in) disable iff (srst_in)
    locked_out |-> !sda_oe_out) // see R07
    else $error("sda driven while locked out");

  // a running conversion is never cut short
  a_sd_waits_conv: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_state == TWS_CONV && conv_cnt != `TWS_CONV_CYC
    |=> conv_state == TWS_CONV) // see R09
    else $error("conversion cut short");

  // shutdown entered from idle when requested
  a_sd_enter: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_state == TWS_IDLE && config1_in[`TWS_SD_BIT]
    |=> shutdown_out) // see R09
    else $error("shutdown not entered");

  // idle restarts the converter at once
  a_continuous: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_state == TWS_IDLE && !config1_in[`TWS_SD_BIT] &&
    sense_in.supply_ok |=> conv_state == TWS_CONV) // see R11
    else $error("conversion not restarted");

  // shutdown left when the request clears
  a_down_exit: assert property (@(posedge clk_in) disable iff (srst_in)
    shutdown_out && !config1_in[`TWS_SD_BIT]
    |=> conv_state == TWS_IDLE) // see R11
    else $error("shutdown not left");

  // no conversion on a bad supply
  a_skip_supply: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_state == TWS_IDLE && !sense_in.supply_ok
    |=> conv_state != TWS_CONV) // see R14
    else $error("converted on bad supply");

  // supply fault marks the taken result
  a_supply_flag: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_end && !sense_in.supply_ok
    |=> temp_result_out[`TWS_SUPPLY_BIT]) // see R15
    else $error("supply fault flag missing");

  // open fault marks the taken result
  a_open_flag: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_end && (open_seen || sense_in.open_fault)
    |=> temp_result_out[`TWS_OPEN_BIT]) // see R13
    else $error("open flag missing");

  // shorted sensor gives the fixed code
  a_short_code: assert property (@(posedge clk_in) disable iff (srst_in)
    conv_end && sense_in.short_fault
    |=> (temp_result_out & 16'hFFFC) == `TWS_SHORT_CODE) // see R12
    else $error("short code missing");

  // speed code byte never acknowledged
  a_hs_nack: assert property (@(posedge clk_in) disable iff (srst_in)
    hs_nack_out |-> !sda_oe_out) // see R02
    else $error("code byte acknowledged");

  // stuck counter cleared while the bus idles high
  a_stuck_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    scl_s && sda_s |=> stuck_cnt == 24'h000000) // see R17
    else $error("stuck counter not cleared");

  // shutdown stops the analog side
  a_analog_off: assert property (@(posedge clk_in) disable iff (srst_in)
    shutdown_out |-> !analog_en_out && !conv_busy_out) // see R10
    else $error("analog on in shutdown");

  // pointer changes only in the pointer slot
  a_ptr_hold: assert property (@(posedge scl_in) disable iff (srst_in)
    !(link_byte_done_in && ptr_slot_l) |=> $stable(ptr_l)) // see R16
    else $error("pointer changed outside its slot");

  // cover points for the main scenarios
  // entry into high-speed mode
  c_hs_entry: cover property (@(posedge clk_in) disable iff (srst_in)
    !hs_mode ##1 hs_mode);
  // bus-stuck timeout
  c_timeout: cover property (@(posedge clk_in) disable iff (srst_in)
    iface_reset_out);
  // conversion finishing into shutdown
  c_shutdown: cover property (@(posedge clk_in) disable iff (srst_in)
    conv_busy_out ##1 !conv_busy_out ##1 shutdown_out);
  // pointer byte taken after a write address
  c_pointer: cover property (@(posedge scl_in) disable iff (srst_in)
    link_byte_done_in && ptr_slot_l && !link_byte_first_in);
endmodule

// File: tws_master_model.sv
// bus master model for the two-wire pins and core byte strobes
`timescale 1ns/1ps
module tws_master_model (
  // bus pins
  output logic scl_out,
  output logic sda_out,
  // byte strobes as the slave core raises them
  output logic [7:0] byte_out,
  output logic first_out,
  output logic done_out
);
  // idle bus: both lines high, clock still
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    byte_out = 8'h00;
    first_out = 1'b0;
    done_out = 1'b0;
  end
  // one short clock pulse while reset is held
  task automatic tick();
    scl_out = 1'b1;
    #10 scl_out = 1'b0;
    #30 scl_out = 1'b1;
  endtask
  // start from idle, or repeated start from a low clock
  task automatic start();
    sda_out = 1'b1;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_out = 1'b0;
    #40 scl_out = 1'b1;
    #40 sda_out = 1'b1;
    #200;
  endtask
  // msb first, ninth clock is the ack slot with data released
  // 160 ns period keeps the clock far above 1 kHz
  task automatic send_byte(input logic [7:0] b, input logic first);
    for (int i = 0; i < 9; i++) begin
      sda_out = (i < 8) ? b[7 - i] : 1'b1;
      if (i == 8) begin
        byte_out = b;
        first_out = first;
        done_out = 1'b1;
      end
      #40 scl_out = 1'b1;
      #80 scl_out = 1'b0;
      done_out = 1'b0;
      #40;
    end
  endtask
endmodule

// File: tb.sv
// self-checking bench for the mode, timeout and status block
`timescale 1ns/1ps
module tb;
  import tws_pkg::*;
  // design pins
  logic clk_in, srst_in, scl, m_sda, sda, core_low, b_first, b_done;
  logic [7:0] b_byte, config1;
  tws_sense_t sense;
  logic [15:0] adc, result;
  logic sda_o, oe, hs, nack, ifr, busy, sdn, aen, rv;
  int n_mismatch, checks_done;
  // rows: byte, first after start, expected speed mode
  logic [9:0] rows [6] = '{{8'h08, 2'b11}, {8'h0F, 2'b11},
    {8'h10, 2'b10}, {8'h07, 2'b10}, {8'h08, 2'b00}, {8'h98, 2'b10}};
  // open-drain data line with pull-up
  assign sda = m_sda & ~oe;
  initial clk_in = 1'b0;
  always #12.5 clk_in = ~clk_in;
  tws_master_model m (.scl_out(scl), .sda_out(m_sda), .byte_out(b_byte),
    .first_out(b_first), .done_out(b_done));
  tws_mode_status DUT (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl),
    .sda_in(sda), .core_sda_low_in(core_low), .link_byte_in(b_byte),
    .link_byte_first_in(b_first), .link_byte_done_in(b_done),
    .config1_in(config1), .sense_in(sense), .adc_result_in(adc),
    .sda_out(sda_o), .sda_oe_out(oe), .hs_mode_out(hs),
    .hs_nack_out(nack), .iface_reset_out(ifr), .conv_busy_out(busy),
    .shutdown_out(sdn), .analog_en_out(aen), .temp_result_out(result),
    .result_valid_out(rv));
  // compare a word
  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // compare a flag
  task automatic chk_bit(input logic e, input logic g);
    chk_word({15'h0000, e}, {15'h0000, g});
  endtask
  // n clock edges, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait for the busy level
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl && n < 6000) begin
      cyc(1);
      n++;
    end
    if (n == 6000) begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, lvl, busy);
    end
  endtask
  // one whole conversion
  task automatic conv_done();
    wait_busy(1'b1);
    wait_busy(1'b0);
    cyc(1);
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog over about twice the expected run
  initial begin
    #1500000;
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    srst_in = 1'b1;
    core_low = 1'b0;
    config1 = 8'h00;
    sense = 3'b001;
    adc = 16'h1A30;
    fork
      m.tick();
      cyc(3);
    join
    srst_in = 1'b0;
    chk_bit(1'b0, hs);
    chk_word(16'h0000, result);
    chk_bit(1'b0, rv);
    $display("test reset done");
    foreach (rows[i]) begin
      m.start();
      m.send_byte(rows[i][9:2], rows[i][1]);
      cyc(8);
      chk_bit(rows[i][0], hs);
      chk_bit(rows[i][0], nack);
      core_low = 1'b1;
      cyc(1);
      chk_bit(~rows[i][0], oe);
      chk_bit(1'b0, sda_o);
      core_low = 1'b0;
      chk_bit(1'b0, ifr);
      m.stop();
      chk_bit(1'b0, hs);
    end
    $display("test speed rows done");
    m.start();
    m.send_byte(8'h08, 1'b1);
    m.start();
    m.send_byte(8'h98, 1'b1);
    cyc(8);
    chk_bit(1'b1, hs);
    m.stop();
    chk_bit(1'b0, hs);
    $display("test restart done");
    conv_done();
    chk_word(16'h1A30, result);
    chk_bit(1'b1, rv);
    sense = 3'b101;
    conv_done();
    conv_done();
    chk_word(16'h1A31, result);
    sense = 3'b011;
    conv_done();
    conv_done();
    chk_word(16'hC000, result);
    sense = 3'b000;
    wait_busy(1'b0);
    cyc(4200);
    chk_bit(1'b0, busy);
    chk_bit(1'b1, result[1]);
    $display("test faults done");
    sense = 3'b001;
    wait_busy(1'b1);
    config1 = 8'h40;
    cyc(1);
    chk_bit(1'b1, busy);
    wait_busy(1'b0);
    cyc(2);
    chk_bit(1'b1, sdn);
    chk_bit(1'b0, aen);
    m.start();
    m.send_byte(8'h0A, 1'b1);
    cyc(8);
    chk_bit(1'b1, hs);
    m.stop();
    m.start();
    m.send_byte(8'h98, 1'b1);
    m.send_byte(8'h05, 1'b0);
    chk_bit(1'b0, nack);
    m.stop();
    chk_bit(1'b1, sdn);
    $display("test shutdown done");
    test_done();
  end
endmodule
